/* design/pcn_map.svh */
// Register offsets, reset values and counts of the pin change and pin select block.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef PCN_MAP_SVH
`define PCN_MAP_SVH
`define PCN_CN_PINS 31
`define PCN_RP_PINS 25
`define PCN_IN_FUNCS 8
`define PCN_OUT_FUNCS 32
`define PCN_DW 16
`define PCN_AW 8
`define PCN_OFF_CHG_EN_LO 8'h00
`define PCN_OFF_CHG_EN_HI 8'h01
`define PCN_OFF_PU_EN_LO 8'h02
`define PCN_OFF_PU_EN_HI 8'h03
`define PCN_OFF_DIR_LO 8'h04
`define PCN_OFF_DIR_HI 8'h05
`define PCN_OFF_LAT_LO 8'h06
`define PCN_OFF_LAT_HI 8'h07
`define PCN_OFF_PORT_LO 8'h08
`define PCN_OFF_PORT_HI 8'h09
`define PCN_OFF_ANA_LO 8'h0A
`define PCN_OFF_ANA_HI 8'h0B
`define PCN_OFF_STATUS 8'h0C
`define PCN_OFF_LOCK 8'h0D
`define PCN_OFF_OMAP 8'h20
`define PCN_OFF_IMAP 8'h40
`define PCN_BIT_CHG_FLAG 0
`define PCN_BIT_LOCKED 0
`define PCN_LOCK_KEY 8'hA5
`define PCN_RST_DIR 25'h1FFFFFF
`define PCN_RST_OMAP 5'h00
`define PCN_RST_IMAP 5'h1F
`endif

/* design/pcn_pkg.sv */
// Types shared by the pin change and pin select modules.
// Assumes pcn_map.svh is on the include path.
`include "pcn_map.svh"
package pcn_pkg;
	typedef logic [`PCN_RP_PINS-1:0][4:0] pcn_omap_t;
	typedef logic [`PCN_IN_FUNCS-1:0][4:0] pcn_imap_t;

	// Three-stage filter: a new level counts once stages two and three agree.
	function automatic logic pcn_filt_t_level(input logic s2, input logic s3, input logic old);
		pcn_filt_t_level = (s2 == s3) ? s3 : old;
	endfunction : pcn_filt_t_level
endpackage : pcn_pkg

/* design/pcn_mux_if.sv */
// Carrier between the register core and the pin output ownership logic.
// Assumes one clock domain; no clocking block.
`timescale 1ns/1ns
`include "pcn_map.svh"
interface pcn_mux_if;
	pcn_pkg::pcn_omap_t omap;
	logic [`PCN_RP_PINS-1:0] dir;
	logic [`PCN_RP_PINS-1:0] lat;
	logic [`PCN_OUT_FUNCS-1:0] func_out;
	logic [`PCN_RP_PINS-1:0] ded_en;
	logic [`PCN_RP_PINS-1:0] ded_out;
	logic [`PCN_RP_PINS-1:0] pmp_en;
	logic [`PCN_RP_PINS-1:0] pmp_out;
	logic [`PCN_RP_PINS-1:0] pmp_oe;
	logic [`PCN_RP_PINS-1:0] pad_out;
	logic [`PCN_RP_PINS-1:0] pad_oe;
	modport ctl (output omap, dir, lat, func_out, ded_en, ded_out, pmp_en, pmp_out, pmp_oe,
		input pad_out, pad_oe);
	modport mux (input omap, dir, lat, func_out, ded_en, ded_out, pmp_en, pmp_out, pmp_oe,
		output pad_out, pad_oe);
endinterface : pcn_mux_if

/* design/pcn_change_det.sv */
// Change detector for the change notification pins.
// Assumes raw pad levels from outside the clock domain and a single system clock.
`timescale 1ns/1ns
`include "pcn_map.svh"
module pcn_change_det (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic [`PCN_CN_PINS-1:0] cn_pad,
	input wire logic [`PCN_CN_PINS-1:0] cn_en,
	output logic chg_pulse,
	output logic wake_req
);
	typedef struct packed {
		logic [`PCN_CN_PINS-1:0] s1;
		logic [`PCN_CN_PINS-1:0] s2;
		logic [`PCN_CN_PINS-1:0] s3;
		logic [`PCN_CN_PINS-1:0] lvl;
		logic [`PCN_CN_PINS-1:0] rec;
		logic pulse;
	} pcn_det_st_t;

	pcn_det_st_t st_ff;
	pcn_det_st_t nxt_st;
	logic [`PCN_CN_PINS-1:0] diff;

	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.s1 = cn_pad;
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
		for (int i = 0; i < `PCN_CN_PINS; i++)
		begin
			nxt_st.lvl[i] = pcn_pkg::pcn_filt_t_level(st_ff.s2[i], st_ff.s3[i], st_ff.lvl[i]);
		end
		diff = cn_en & (st_ff.lvl ^ st_ff.rec); // see RULE20 see RULE4
		nxt_st.pulse = |diff; // see RULE1
		nxt_st.rec = st_ff.lvl; // see RULE20
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			st_ff <= '0;
		else if (clk_en)
			st_ff <= nxt_st;
	end

	assign chg_pulse = st_ff.pulse;
	// Clockless compare of raw pads against recorded levels wakes a stopped device.
	assign wake_req = |(cn_en & (cn_pad ^ st_ff.rec)); // see RULE2
endmodule : pcn_change_det

/* design/pcn_pin_mux.sv */
// Output ownership of the remappable pins.
// Assumes configuration arrives registered from the register core.
`timescale 1ns/1ns
`include "pcn_map.svh"
module pcn_pin_mux (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	pcn_mux_if.mux mx
);
	typedef struct packed {
		logic [`PCN_RP_PINS-1:0] out;
		logic [`PCN_RP_PINS-1:0] oe;
	} pcn_mux_st_t;

	pcn_mux_st_t st_ff;
	pcn_mux_st_t nxt_st;

	always_comb
	begin
		nxt_st = st_ff;
		for (int i = 0; i < `PCN_RP_PINS; i++)
		begin
			if (mx.ded_en[i])
			begin
				nxt_st.out[i] = mx.ded_out[i]; // see RULE13
				nxt_st.oe[i] = 1'b1;
			end
			else if (mx.omap[i] != `PCN_RST_OMAP)
			begin
				nxt_st.out[i] = mx.func_out[mx.omap[i]]; // see RULE12 see RULE11
				nxt_st.oe[i] = 1'b1;
			end
			else if (mx.pmp_en[i])
			begin
				nxt_st.out[i] = mx.pmp_out[i];
				nxt_st.oe[i] = mx.pmp_oe[i];
			end
			else
			begin
				nxt_st.out[i] = mx.lat[i];
				nxt_st.oe[i] = ~mx.dir[i]; // see RULE14 see RULE17
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			st_ff <= '0;
		else if (clk_en)
			st_ff <= nxt_st;
	end

	assign mx.pad_out = st_ff.out;
	assign mx.pad_oe = st_ff.oe;
endmodule : pcn_pin_mux

/* design/pcn_top.sv */
// Register core of the pin change notification and remappable pin select block.
// Assumes a single 10 MHz clock, synchronous reset and a plain register port.
`timescale 1ns/1ns
`include "pcn_map.svh"
// Summary of operation
// RULE1 - Any enabled change notification pin changing state raises the request.
// RULE2 - Change detection also works in sleep with the clock stopped.
// RULE3 - Up to 31 change notification pins, each selectable.
// RULE4 - Per-pin change enable bits, split over low and high registers.
// RULE5 - Per-pin pull-up enable bits, split over low and high registers.
// RULE6 - Software clears the pull-up of a pin used as a digital output.
// RULE7 - Pin select covers 25 numbered digital pins.
// RULE8 - Peripheral inputs and outputs are mapped independently.
// RULE9 - A lock guards the mapping against accidental changes.
// RULE10 - Change pins and other fixed functions are never remappable.
// RULE11 - A remappable peripheral reaches no pin until assigned.
// RULE12 - A mapped output wins over port latch and parallel master port.
// RULE13 - Dedicated outputs such as USB win over mapped outputs.
// RULE14 - Mapped inputs never drive a pin; direction bit rules the buffer.
// RULE15 - In digital mode a mapped input receives the pin level.
// RULE16 - An analog pin disables the mapped input tied to it.
// RULE17 - Direction bit one means input; all pins are inputs after reset.
// RULE18 - Software waits one cycle between a port write and a read.
// RULE19 - Port reads return zero on analog pins.
// RULE20 - Changes compare present and recorded levels, recorded level then updates.
module pcn_top (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic [`PCN_AW-1:0] reg_addr,
	input wire logic [`PCN_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [`PCN_DW-1:0] reg_rdata,
	input wire logic [`PCN_CN_PINS-1:0] cn_pad,
	output logic [`PCN_CN_PINS-1:0] cn_pullup_en,
	output logic change_irq,
	output logic wake_req,
	input wire logic [`PCN_RP_PINS-1:0] rp_pad_in,
	output logic [`PCN_RP_PINS-1:0] rp_pad_out,
	output logic [`PCN_RP_PINS-1:0] rp_pad_oe,
	input wire logic [`PCN_OUT_FUNCS-1:0] func_out,
	output logic [`PCN_IN_FUNCS-1:0] func_in,
	input wire logic [`PCN_RP_PINS-1:0] ded_en,
	input wire logic [`PCN_RP_PINS-1:0] ded_out,
	input wire logic [`PCN_RP_PINS-1:0] pmp_en,
	input wire logic [`PCN_RP_PINS-1:0] pmp_out,
	input wire logic [`PCN_RP_PINS-1:0] pmp_oe
);
	// ******************************************************************
	// State.
	// ******************************************************************
	typedef struct packed {
		logic [`PCN_CN_PINS-1:0] chg_en;
		logic [`PCN_CN_PINS-1:0] pu_en;
		logic [`PCN_RP_PINS-1:0] dir;
		logic [`PCN_RP_PINS-1:0] lat;
		logic [`PCN_RP_PINS-1:0] ana;
		logic [`PCN_RP_PINS-1:0] s1;
		logic [`PCN_RP_PINS-1:0] s2;
		logic [`PCN_RP_PINS-1:0] s3;
		logic [`PCN_RP_PINS-1:0] lvl;
		pcn_pkg::pcn_omap_t omap;
		pcn_pkg::pcn_imap_t imap;
		logic [`PCN_IN_FUNCS-1:0] fin;
		logic chg_flag;
		logic locked;
		logic [`PCN_DW-1:0] rdata;
	} pcn_top_st_t;

	localparam pcn_top_st_t PCN_RST_ST = '{
		chg_en: '0,
		pu_en: '0,
		dir: `PCN_RST_DIR,
		lat: '0,
		ana: '0,
		s1: '0,
		s2: '0,
		s3: '0,
		lvl: '0,
		omap: {`PCN_RP_PINS{`PCN_RST_OMAP}},
		imap: {`PCN_IN_FUNCS{`PCN_RST_IMAP}},
		fin: '0,
		chg_flag: 1'b0,
		locked: 1'b0,
		rdata: '0
	};

	pcn_top_st_t st_ff;
	pcn_top_st_t nxt_st;
	logic chg_pulse;
	logic [`PCN_RP_PINS-1:0] port_val;
	logic [4:0] oidx;
	logic [4:0] iidx;
	logic [4:0] sel;

	pcn_mux_if mx ();

	// ******************************************************************
	// Address decode.
	// ******************************************************************
	// Tells whether an index falls in a window of n words starting at base.
	function automatic logic pcn_in_window(input logic [`PCN_AW-1:0] a,
		input logic [`PCN_AW-1:0] base, input logic [`PCN_AW-1:0] n);
		pcn_in_window = (a >= base) && (8'(a - base) < n);
	endfunction : pcn_in_window

	// ******************************************************************
	// Change detector.
	// ******************************************************************
	pcn_change_det u_det (
		.clk(clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.cn_pad(cn_pad),
		.cn_en(st_ff.chg_en),
		.chg_pulse(chg_pulse),
		.wake_req(wake_req)
	);

	// ******************************************************************
	// Pin output ownership.
	// ******************************************************************
	pcn_pin_mux u_mux (
		.clk(clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.mx(mx.mux)
	);

	assign mx.omap = st_ff.omap;
	assign mx.dir = st_ff.dir;
	assign mx.lat = st_ff.lat;
	assign mx.func_out = func_out;
	assign mx.ded_en = ded_en;
	assign mx.ded_out = ded_out;
	assign mx.pmp_en = pmp_en;
	assign mx.pmp_out = pmp_out;
	assign mx.pmp_oe = pmp_oe;

	// ******************************************************************
	// Register access and pin input paths.
	// ******************************************************************
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.rdata = '0;
		oidx = 5'(reg_addr - `PCN_OFF_OMAP);
		iidx = 5'(reg_addr - `PCN_OFF_IMAP);
		sel = '0;
		nxt_st.s1 = rp_pad_in;
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
		for (int i = 0; i < `PCN_RP_PINS; i++)
		begin
			nxt_st.lvl[i] = pcn_pkg::pcn_filt_t_level(st_ff.s2[i], st_ff.s3[i], st_ff.lvl[i]);
		end
		port_val = st_ff.lvl & ~st_ff.ana; // see RULE19
		for (int j = 0; j < `PCN_IN_FUNCS; j++)
		begin
			sel = st_ff.imap[j];
			if (sel < 5'(`PCN_RP_PINS))
				nxt_st.fin[j] = st_ff.lvl[sel] & ~st_ff.ana[sel]; // see RULE15 see RULE16
			else
				nxt_st.fin[j] = 1'b0; // see RULE11
		end
		if (reg_wr)
		begin
			if (reg_addr == `PCN_OFF_CHG_EN_LO)
				nxt_st.chg_en[15:0] = reg_wdata; // see RULE4 see RULE3
			else if (reg_addr == `PCN_OFF_CHG_EN_HI)
				nxt_st.chg_en[30:16] = reg_wdata[14:0]; // see RULE4
			else if (reg_addr == `PCN_OFF_PU_EN_LO)
				nxt_st.pu_en[15:0] = reg_wdata; // see RULE5
			else if (reg_addr == `PCN_OFF_PU_EN_HI)
				nxt_st.pu_en[30:16] = reg_wdata[14:0]; // see RULE5
			else if (reg_addr == `PCN_OFF_DIR_LO)
				nxt_st.dir[15:0] = reg_wdata; // see RULE17
			else if (reg_addr == `PCN_OFF_DIR_HI)
				nxt_st.dir[24:16] = reg_wdata[8:0]; // see RULE17
			else if (reg_addr == `PCN_OFF_LAT_LO || reg_addr == `PCN_OFF_PORT_LO)
				nxt_st.lat[15:0] = reg_wdata;
			else if (reg_addr == `PCN_OFF_LAT_HI || reg_addr == `PCN_OFF_PORT_HI)
				nxt_st.lat[24:16] = reg_wdata[8:0];
			else if (reg_addr == `PCN_OFF_ANA_LO)
				nxt_st.ana[15:0] = reg_wdata;
			else if (reg_addr == `PCN_OFF_ANA_HI)
				nxt_st.ana[24:16] = reg_wdata[8:0];
			else if (reg_addr == `PCN_OFF_STATUS && reg_wdata[`PCN_BIT_CHG_FLAG])
				nxt_st.chg_flag = 1'b0;
			else if (reg_addr == `PCN_OFF_LOCK && reg_wdata[15:8] == `PCN_LOCK_KEY)
				nxt_st.locked = reg_wdata[`PCN_BIT_LOCKED]; // see RULE9
			else if (pcn_in_window(reg_addr, `PCN_OFF_OMAP, 8'(`PCN_RP_PINS)))
			begin
				if (!st_ff.locked)
					nxt_st.omap[oidx] = reg_wdata[4:0]; // see RULE8 see RULE9 see RULE7
			end
			else if (pcn_in_window(reg_addr, `PCN_OFF_IMAP, 8'(`PCN_IN_FUNCS)))
			begin
				if (!st_ff.locked)
					nxt_st.imap[iidx[2:0]] = reg_wdata[4:0]; // see RULE8 see RULE9
			end
		end
		if (chg_pulse)
			nxt_st.chg_flag = 1'b1; // see RULE1
		if (reg_rd)
		begin
			if (reg_addr == `PCN_OFF_CHG_EN_LO)
				nxt_st.rdata = st_ff.chg_en[15:0];
			else if (reg_addr == `PCN_OFF_CHG_EN_HI)
				nxt_st.rdata = {1'b0, st_ff.chg_en[30:16]};
			else if (reg_addr == `PCN_OFF_PU_EN_LO)
				nxt_st.rdata = st_ff.pu_en[15:0];
			else if (reg_addr == `PCN_OFF_PU_EN_HI)
				nxt_st.rdata = {1'b0, st_ff.pu_en[30:16]};
			else if (reg_addr == `PCN_OFF_DIR_LO)
				nxt_st.rdata = st_ff.dir[15:0];
			else if (reg_addr == `PCN_OFF_DIR_HI)
				nxt_st.rdata = {7'h00, st_ff.dir[24:16]};
			else if (reg_addr == `PCN_OFF_LAT_LO)
				nxt_st.rdata = st_ff.lat[15:0];
			else if (reg_addr == `PCN_OFF_LAT_HI)
				nxt_st.rdata = {7'h00, st_ff.lat[24:16]};
			else if (reg_addr == `PCN_OFF_PORT_LO)
				nxt_st.rdata = port_val[15:0]; // see RULE19
			else if (reg_addr == `PCN_OFF_PORT_HI)
				nxt_st.rdata = {7'h00, port_val[24:16]}; // see RULE19
			else if (reg_addr == `PCN_OFF_ANA_LO)
				nxt_st.rdata = st_ff.ana[15:0];
			else if (reg_addr == `PCN_OFF_ANA_HI)
				nxt_st.rdata = {7'h00, st_ff.ana[24:16]};
			else if (reg_addr == `PCN_OFF_STATUS)
				nxt_st.rdata = {15'h0000, st_ff.chg_flag};
			else if (reg_addr == `PCN_OFF_LOCK)
				nxt_st.rdata = {15'h0000, st_ff.locked};
			else if (pcn_in_window(reg_addr, `PCN_OFF_OMAP, 8'(`PCN_RP_PINS)))
				nxt_st.rdata = {11'h000, st_ff.omap[oidx]};
			else if (pcn_in_window(reg_addr, `PCN_OFF_IMAP, 8'(`PCN_IN_FUNCS)))
				nxt_st.rdata = {11'h000, st_ff.imap[iidx[2:0]]};
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			st_ff <= PCN_RST_ST;
		else if (clk_en)
			st_ff <= nxt_st;
	end

	// ******************************************************************
	// Outputs.
	// ******************************************************************
	// Change pins stay on fixed pads and never pass through the pin mux.
	assign cn_pullup_en = st_ff.pu_en; // see RULE5 see RULE10
	assign change_irq = st_ff.chg_flag; // see RULE1
	assign reg_rdata = st_ff.rdata;
	assign func_in = st_ff.fin;
	assign rp_pad_out = mx.pad_out;
	assign rp_pad_oe = mx.pad_oe;
endmodule : pcn_top

/* verif/pcn_top_properties.sv */
// Port checks of the pin change and pin select block.
// Assumes one clock and the offsets of pcn_map.svh.
`timescale 1ns/1ns
`include "pcn_map.svh"
module pcn_top_properties (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic [`PCN_AW-1:0] reg_addr,
	input wire logic [`PCN_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [`PCN_DW-1:0] reg_rdata,
	input wire logic [`PCN_CN_PINS-1:0] cn_pad,
	input wire logic [`PCN_CN_PINS-1:0] cn_pullup_en,
	input wire logic change_irq,
	input wire logic wake_req,
	input wire logic [`PCN_RP_PINS-1:0] rp_pad_in,
	input wire logic [`PCN_RP_PINS-1:0] rp_pad_out,
	input wire logic [`PCN_RP_PINS-1:0] rp_pad_oe,
	input wire logic [`PCN_IN_FUNCS-1:0] func_in,
	input wire logic [`PCN_RP_PINS-1:0] ded_en,
	input wire logic [`PCN_RP_PINS-1:0] ded_out
);
	// ********
	// Checks
	// ********
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic [3:0] since_wake_ff;
	// Counts cycles since the wake request was last seen.
	always_ff @(posedge clk)
		since_wake_ff <= (sys_rst || !wake_req) ? ((since_wake_ff == 4'hF || sys_rst) ? 4'hF :
			since_wake_ff + 4'h1) : 4'h0;
	AST_RDATA_IDLE: assert property (reg_rdata != 16'h0000 |-> $past(reg_rd))
		else $error("Read data seen without a read.");
	AST_RESET_STATE: assert property ($fell(sys_rst) |-> rp_pad_oe == 25'h0 &&
		func_in == 8'h00 && cn_pullup_en == 31'h0 && !change_irq)
		else $error("Outputs not in reset state.");
	AST_DED_WINS: assert property ($past(clk_en) |->
		(rp_pad_oe & $past(ded_en)) == $past(ded_en) &&
		((rp_pad_out ^ $past(ded_out)) & $past(ded_en)) == 25'h0)
		else $error("Dedicated output lost the pin.");
	AST_IRQ_STICKY: assert property (change_irq && !reg_wr |=> change_irq)
		else $error("Change request dropped without a clear.");
	AST_IRQ_CLEAR: assert property ((clk_en && $stable(cn_pad)) [*8] ##0
		(reg_wr && reg_addr == `PCN_OFF_STATUS && reg_wdata[0]) |=> !change_irq)
		else $error("Change request not cleared.");
	AST_WAKE_FIRST: assert property ($rose(change_irq) |-> since_wake_ff <= 4'h7)
		else $error("Change request without a wake request.");
	AST_FUNCIN_STEADY: assert property (
		(clk_en && !reg_wr && $stable(rp_pad_in)) [*6] |-> $stable(func_in))
		else $error("Mapped input moved with steady pins.");
	AST_PU_BY_WRITE: assert property (
		!$stable(cn_pullup_en) |-> $past(reg_wr && reg_addr[7:1] == 7'h01))
		else $error("Pull-up enables moved without a write.");
endmodule : pcn_top_properties
bind pcn_top pcn_top_properties props (.*);

/* verif/pcn_pad_model.sv */
// Pads and wiring outside the block.
// Assumes the bench sets the outside levels.
`timescale 1ns/1ns
`include "pcn_map.svh"
module pcn_pad_model (
	input wire logic clk,
	input wire logic [`PCN_CN_PINS-1:0] cn_ext,
	input wire logic [`PCN_CN_PINS-1:0] cn_drv,
	input wire logic [`PCN_CN_PINS-1:0] cn_pullup_en,
	input wire logic [`PCN_RP_PINS-1:0] rp_ext,
	input wire logic [`PCN_RP_PINS-1:0] rp_pad_out,
	input wire logic [`PCN_RP_PINS-1:0] rp_pad_oe,
	output logic [`PCN_CN_PINS-1:0] cn_pad,
	output logic [`PCN_RP_PINS-1:0] rp_pad_in
);
	// ********
	// Pin levels
	// ********
	logic [`PCN_CN_PINS-1:0] float_ff = '0;
	always @(posedge clk) float_ff <= ~float_ff;
	// A released pin rises on its pull-up, otherwise it wanders.
	assign cn_pad = (cn_ext & cn_drv) | (~cn_drv & (cn_pullup_en | float_ff));
	// A pin that the block drives shows the block's level.
	assign rp_pad_in = (rp_pad_oe & rp_pad_out) | (~rp_pad_oe & rp_ext);
endmodule : pcn_pad_model

/* verif/tb.sv */
// Self-checking bench of the pin change and pin select block.
// Assumes the design files and the pad model are compiled first.
`timescale 1ns/1ns
`include "pcn_map.svh"
module tb;
	logic clk, sys_rst, clk_en, reg_wr, reg_rd, change_irq, wake_req;
	logic [`PCN_AW-1:0] reg_addr;
	logic [`PCN_DW-1:0] reg_wdata, reg_rdata, rd_v;
	logic [`PCN_CN_PINS-1:0] cn_ext, cn_drv, cn_pad, cn_pullup_en;
	logic [`PCN_RP_PINS-1:0] rp_ext, rp_pad_in, rp_pad_out, rp_pad_oe;
	logic [`PCN_RP_PINS-1:0] ded_en, ded_out, pmp_en, pmp_out, pmp_oe;
	logic [`PCN_OUT_FUNCS-1:0] func_out;
	logic [`PCN_IN_FUNCS-1:0] func_in;
	logic [31:0] seed, r, dv, lv, av;
	logic [4:0] mp [25];
	logic [4:0] sel [8];
	int n_mismatch, compares, p, k;
	pcn_top dut (.*);
	pcn_pad_model pads (.*);
	// ********
	// Helpers
	// ********
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	function automatic logic [1:0] exp_pad(input int i);
		if (ded_en[i])
			return {1'b1, ded_out[i]};
		if (mp[i] != 5'h00)
			return {1'b1, func_out[mp[i]]};
		if (pmp_en[i])
			return {pmp_oe[i], pmp_out[i]};
		return {~dv[i], lv[i]};
	endfunction : exp_pad
	function automatic logic exp_in(input logic [4:0] s);
		if (s >= 5'h19)
			return 1'b0;
		return rp_ext[s] & ~av[s];
	endfunction : exp_in
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		{reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rchk(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk);
		{reg_rd, reg_addr} <= {1'b1, a};
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rd_v = reg_rdata;
		chk(rd_v, e);
	endtask : rchk
	task automatic complete_run();
		if (n_mismatch == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : complete_run
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial
	begin
		#2000000;
		n_mismatch++;
		complete_run();
	end
	// ********
	// Scenarios
	// ********
	initial
	begin
		seed = 32'hF2A7;
		{clk_en, sys_rst, cn_drv} = '1;
		{reg_wr, reg_rd, reg_addr, reg_wdata, cn_ext, rp_ext} = '0;
		{func_out, ded_en, ded_out, pmp_en, pmp_out, pmp_oe} = '0;
		foreach (mp[i]) mp[i] = 5'h00;
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		rchk(`PCN_OFF_DIR_LO, 16'hFFFF);
		rchk(`PCN_OFF_DIR_HI, 16'h01FF);
		rchk(`PCN_OFF_OMAP, 16'h0000);
		rchk(`PCN_OFF_IMAP, 16'h001F);
		for (k = 0; k < 12; k++)
		begin
			r = rnd();
			if (k != 8 && k != 9)
			begin
				wr(8'(k), r[15:0]);
				rchk(8'(k), r[15:0] & (k % 2 == 0 ? 16'hFFFF : k < 4 ? 16'h7FFF : 16'h01FF));
			end
		end
		wr(8'h10, 16'hFFFF);
		rchk(8'h10, 16'h0000);
		r = rnd() | 32'h2;
		wr(`PCN_OFF_PU_EN_LO, r[15:0]);
		wr(`PCN_OFF_PU_EN_HI, r[31:16]);
		@(posedge clk) cn_drv[1] <= 1'b0;
		@(negedge clk);
		chk(cn_pullup_en, r[30:0]);
		chk(cn_pad[1], 1'b1);
		@(posedge clk) cn_drv[1] <= 1'b1;
		wr(`PCN_OFF_CHG_EN_LO, 16'hFFFF);
		wr(`PCN_OFF_CHG_EN_HI, 16'h7FFF);
		repeat (10) @(posedge clk);
		wr(`PCN_OFF_STATUS, 16'h0001);
		for (k = 0; k < 6; k++)
		begin
			p = (k == 0) ? 30 : int'(rnd() % 31);
			@(posedge clk) cn_ext[p] <= ~cn_ext[p];
			repeat (10) @(posedge clk);
			rchk(`PCN_OFF_STATUS, 16'h0001);
			wr(`PCN_OFF_STATUS, 16'h0001);
			rchk(`PCN_OFF_STATUS, 16'h0000);
		end
		wr(`PCN_OFF_CHG_EN_LO, 16'h0000);
		@(posedge clk) cn_ext[3] <= ~cn_ext[3];
		repeat (10) @(posedge clk);
		wr(`PCN_OFF_CHG_EN_LO, 16'hFFFF);
		repeat (10) @(negedge clk);
		chk(change_irq, 1'b0);
		@(posedge clk) {clk_en, cn_ext[5]} <= {1'b0, ~cn_ext[5]};
		@(negedge clk);
		chk(wake_req, 1'b1);
		repeat (4) @(posedge clk);
		clk_en <= 1'b1;
		repeat (10) @(negedge clk);
		chk(change_irq, 1'b1);
		wr(`PCN_OFF_STATUS, 16'h0001);
		wr(`PCN_OFF_PU_EN_LO, 16'h0000);
		wr(`PCN_OFF_PU_EN_HI, 16'h0000);
		for (k = 0; k < 10; k++)
		begin
			p = int'(rnd() % 25);
			r = rnd();
			mp[p] = r[4:0] & {5{r[5]}};
			wr(8'(`PCN_OFF_OMAP + p), {11'h000, mp[p]});
			dv = rnd();
			lv = rnd();
			wr(`PCN_OFF_DIR_LO, dv[15:0]);
			wr(`PCN_OFF_DIR_HI, dv[31:16]);
			wr(`PCN_OFF_LAT_LO, lv[15:0]);
			wr(`PCN_OFF_LAT_HI, lv[31:16]);
			@(posedge clk) {ded_en, ded_out} <= {25'(rnd() & rnd() & rnd()), 25'(rnd())};
			{pmp_en, pmp_out, pmp_oe, func_out} <= {25'(rnd()), 25'(rnd()), 25'(rnd()), rnd()};
			repeat (2) @(negedge clk);
			for (p = 0; p < 25; p++)
				chk({rp_pad_oe[p], rp_pad_out[p]}, exp_pad(p));
		end
		@(posedge clk) {ded_en, pmp_en} <= '0;
		wr(`PCN_OFF_DIR_LO, 16'hFFFF);
		wr(`PCN_OFF_DIR_HI, 16'h01FF);
		for (k = 0; k < 25; k++)
			wr(8'(`PCN_OFF_OMAP + k), 16'h0000);
		for (k = 0; k < 8; k++)
		begin
			sel[k] = (k == 6) ? 5'h19 : 5'(rnd() % 25);
			wr(8'(`PCN_OFF_IMAP + k), {11'h000, sel[k]});
		end
		for (k = 0; k < 6; k++)
		begin
			av = (k == 0) ? 32'h0 : rnd();
			wr(`PCN_OFF_ANA_LO, av[15:0]);
			wr(`PCN_OFF_ANA_HI, av[31:16]);
			@(posedge clk) rp_ext <= 25'(rnd());
			repeat (8) @(negedge clk);
			for (p = 0; p < 8; p++)
				chk(func_in[p], exp_in(sel[p]));
			chk(rp_pad_oe, 25'h0);
			rchk(`PCN_OFF_PORT_LO, rp_ext[15:0] & ~av[15:0]);
		end
		wr(`PCN_OFF_LOCK, 16'hA501);
		wr(`PCN_OFF_OMAP + 8'h03, 16'h0007);
		rchk(`PCN_OFF_OMAP + 8'h03, 16'h0000);
		wr(`PCN_OFF_LOCK, 16'h0000);
		rchk(`PCN_OFF_LOCK, 16'h0001);
		wr(`PCN_OFF_LOCK, 16'hA500);
		wr(`PCN_OFF_OMAP + 8'h03, 16'h0007);
		rchk(`PCN_OFF_OMAP + 8'h03, 16'h0007);
		complete_run();
	end
endmodule : tb
